/* File: pkg/strap_pkg.sv */
// Constants, types and decode helpers for the startup strap loader.
// Contract
// [RULE1] Foldback lowers advertisement only, nothing else
// [RULE2] Bus parts: three-bit field picks eight limits
// [RULE3] Strap parts: limit subset from third strap
// [RULE4] Five-bit gain: strap two low, three top
// [RULE5] Remote sense leaves programmed gain unchanged
// [RULE6] Enable high, logic supply low: invalid mode
// [RULE7] Negotiated role swap needs no software
// [RULE8] Unnegotiated swap: host keeps pass-through mode
// [RULE9] Charge select low starts in pass-through
// [RULE10] Bus parts preload strap one at enable
// [RULE11] Step decides spread spectrum and sync direction
// [RULE12] Step low bits give address low bits
// [RULE13] Strap parts: step low bits pick frequency
// [RULE14] Strap parts reuse serial pins as straps
// [RULE15] Third strap sets limit, advertisement, foldback, gain
// [RULE16] Third strap table for limit and advertisement
// [RULE17] Strap step code 0..15, open reads 15
// [RULE18] Enable low: switches off; auto mode by detect
package strap_pkg;

    localparam int STEP_W = 4;
    localparam int AXI_AW = 8;
    localparam logic [3:0] STEP_OPEN = 4'hF;

    // Register byte offsets.
    localparam logic [7:0] OFS_SETUP0 = 8'h00;
    localparam logic [7:0] OFS_SETUP1 = 8'h04;
    localparam logic [7:0] OFS_SETUP2 = 8'h08;
    localparam logic [7:0] OFS_CTRL = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // Field positions.
    localparam int POS_SPREAD = 0;
    localparam int POS_SYNCIN = 1;
    localparam int POS_ADDR = 4;
    localparam int POS_FREQ = 0;
    localparam int POS_GAIN = 4;
    localparam int POS_LIMIT = 0;
    localparam int POS_ADV = 4;
    localparam int POS_FOLD = 8;
    localparam int POS_CHGDET = 0;
    localparam int POS_MODE = 0;
    localparam int POS_ADVNOW = 4;
    localparam int POS_WARN = 8;
    localparam int POS_STRAPPART = 9;

    // Oscillator frequency codes.
    localparam logic [2:0] FREQ_2200K = 3'h0;
    localparam logic [2:0] FREQ_488K = 3'h4;
    localparam logic [2:0] FREQ_350K = 3'h6;
    localparam logic [2:0] FREQ_310K = 3'h7;

    // Current limit codes for 0.55, 1.62, 2.60 and 3.04 A.
    localparam logic [2:0] LIM_0A55 = 3'h0;
    localparam logic [2:0] LIM_1A62 = 3'h3;
    localparam logic [2:0] LIM_2A60 = 3'h5;
    localparam logic [2:0] LIM_3A04 = 3'h7;

    // Advertised source current codes.
    localparam logic [1:0] ADV_0A5 = 2'h0;
    localparam logic [1:0] ADV_1A5 = 2'h1;
    localparam logic [1:0] ADV_3A0 = 2'h2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        MODE_OFF = 4'b0001,
        MODE_PASS = 4'b0010,
        MODE_CDP = 4'b0100,
        MODE_INVALID = 4'b1000
    } switch_mode_t;

    typedef struct packed {
        logic spreadOn;
        logic syncDirIn;
        logic [1:0] slaveAddrLsb;
        logic [2:0] oscFrequencySelect;
        logic [4:0] gain;
        logic [2:0] limitValue;
        logic [1:0] advertisedSourceCurrent;
        logic thermalFoldbackOn;
    } settings_t;

    localparam settings_t SETTINGS_RESET = '{
        spreadOn: 1'b1, syncDirIn: 1'b1, slaveAddrLsb: 2'h0,
        oscFrequencySelect: FREQ_2200K, gain: 5'h00, limitValue: LIM_3A04,
        advertisedSourceCurrent: ADV_3A0, thermalFoldbackOn: 1'b1};

    function automatic logic [3:0] step_code(input logic [3:0] raw, input logic open);
        step_code = open ? STEP_OPEN : raw;
    endfunction

    function automatic logic [2:0] freq_of(input logic [1:0] s);
        unique case (s)
            2'h0: freq_of = FREQ_2200K;
            2'h1: freq_of = FREQ_488K;
            2'h2: freq_of = FREQ_350K;
            2'h3: freq_of = FREQ_310K;
        endcase
    endfunction

    function automatic logic [2:0] limit_of(input logic [1:0] s);
        unique case (s)
            2'h0: limit_of = LIM_0A55;
            2'h1: limit_of = LIM_1A62;
            2'h2: limit_of = LIM_2A60;
            2'h3: limit_of = LIM_3A04;
        endcase
    endfunction

    function automatic logic [1:0] adv_of(input logic [1:0] s);
        unique case (s)
            2'h0: adv_of = ADV_0A5;
            2'h1: adv_of = ADV_1A5;
            2'h2: adv_of = ADV_1A5;
            2'h3: adv_of = ADV_3A0;
        endcase
    endfunction

endpackage

/* File: logic/pin_sync.sv */
// Two-stage synchroniser for a group of asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Pins in and synchronised copy out.
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinOut
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            meta_q <= '0;
            pinOut <= '0;
        end
        else
        begin
            meta_q <= pinIn;
            pinOut <= meta_q;
        end
    end
endmodule // pin_sync
`default_nettype wire

/* File: logic/startup_config.sv */
// Strap loader, data-switch mode selector and its AXI4-Lite register file.
`timescale 1ns/1ps
`default_nettype none
module startup_config (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // AXI4-Lite write channels.
    input wire logic [strap_pkg::AXI_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels.
    input wire logic [strap_pkg::AXI_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Strap step codes and open flags from the resistor measurement.
    input wire logic [3:0] strapOne,
    input wire logic [3:0] strapTwo,
    input wire logic [3:0] strapThree,
    input wire logic [2:0] strapOpen,
    input wire logic busVariant,
    // Control pins.
    input wire logic highVoltageEnable,
    input wire logic logicSupplyOk,
    input wire logic chargeModeSelect,
    input wire logic portDetect,
    input wire logic thermalWarn,
    input wire logic remoteSenseOn,
    // Settings and switch controls.
    output strap_pkg::settings_t settings,
    output logic [1:0] advertisedNow,
    output strap_pkg::switch_mode_t switchMode,
    output logic switchA,
    output logic switchB,
    output logic serialPinsAsStraps,
    output logic remoteCompActive
);
    import strap_pkg::*;

    localparam int PIN_W = 22;

    logic [PIN_W-1:0] pinSync;
    logic [3:0] rawOne;
    logic [3:0] rawTwo;
    logic [3:0] rawThree;
    logic [2:0] openS;
    logic busS;
    logic hvS;
    logic supS;
    logic chgS;
    logic detS;
    logic warnS;
    logic remS;
    logic [3:0] stepOne;
    logic [3:0] stepTwo;
    logic [3:0] stepThree;
    logic hvPrev_q;
    logic hvRise;
    settings_t setup_d;
    logic [1:0] chargeDetectCtrl_q;
    logic awHeld_q;
    logic wHeld_q;
    logic [AXI_AW-1:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic doWrite;
    logic writeHit;
    logic [31:0] readWord;
    logic readHit;
    logic cdpWanted;

    pin_sync #(
        .WIDTH(PIN_W)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .pinIn({strapOne, strapTwo, strapThree, strapOpen, busVariant, highVoltageEnable,
                logicSupplyOk, chargeModeSelect, portDetect, thermalWarn, remoteSenseOn}),
        .pinOut(pinSync)
    );

    assign {rawOne, rawTwo, rawThree, openS, busS, hvS, supS, chgS, detS, warnS, remS} = pinSync;

    assign stepOne = step_code(rawOne, openS[2]); // RULE17
    assign stepTwo = step_code(rawTwo, openS[1]); // RULE17
    assign stepThree = step_code(rawThree, openS[0]); // RULE17
    assign hvRise = hvS && !hvPrev_q;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            hvPrev_q <= 1'b0;
        end
        else
        begin
            hvPrev_q <= hvS;
        end
    end

    // Merges byte lanes of a write into an old register word.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        merge = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                merge[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
    endfunction

    assign doWrite = awHeld_q && wHeld_q && !bvalid;
    assign writeHit = (awAddr_q == OFS_SETUP0) || (awAddr_q == OFS_SETUP1)
        || (awAddr_q == OFS_SETUP2) || (awAddr_q == OFS_CTRL) || (awAddr_q == OFS_STATUS);

    // Software writes, then the enable-edge preload taking priority.
    always_comb
    begin
        logic [31:0] w;
        w = '0;
        setup_d = settings;
        if (doWrite && busS)
        begin
            unique case (awAddr_q)
                OFS_SETUP0:
                begin
                    w = merge({26'h0, settings.slaveAddrLsb, 2'h0, settings.syncDirIn,
                               settings.spreadOn}, wData_q, wStrb_q);
                    setup_d.spreadOn = w[POS_SPREAD];
                    setup_d.syncDirIn = w[POS_SYNCIN];
                end
                OFS_SETUP1:
                begin
                    w = merge({23'h0, settings.gain, 1'b0, settings.oscFrequencySelect},
                              wData_q, wStrb_q);
                    setup_d.oscFrequencySelect = w[POS_FREQ +: 3];
                    setup_d.gain = w[POS_GAIN +: 5]; // RULE4
                end
                OFS_SETUP2:
                begin
                    w = merge({23'h0, settings.thermalFoldbackOn, 2'h0,
                               settings.advertisedSourceCurrent, 1'b0, settings.limitValue},
                              wData_q, wStrb_q);
                    setup_d.limitValue = w[POS_LIMIT +: 3]; // RULE2
                    setup_d.advertisedSourceCurrent = w[POS_ADV +: 2];
                    setup_d.thermalFoldbackOn = w[POS_FOLD];
                end
                default:
                begin
                    w = '0;
                end
            endcase
        end
        if (hvRise)
        begin
            setup_d.spreadOn = !stepOne[3]; // RULE11
            setup_d.syncDirIn = !stepOne[2]; // RULE11
            setup_d.slaveAddrLsb = stepOne[1:0]; // RULE12
            if (!busS)
            begin
                setup_d.oscFrequencySelect = freq_of(stepOne[1:0]); // RULE13
                setup_d.gain = {stepThree[2], stepTwo}; // RULE4
                setup_d.limitValue = limit_of(stepThree[1:0]); // RULE3 RULE16
                setup_d.advertisedSourceCurrent = adv_of(stepThree[1:0]); // RULE16
                setup_d.thermalFoldbackOn = !stepThree[3]; // RULE15
            end
        end
    end

    // Preload at the enable edge; bus parts may overwrite later.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            settings <= SETTINGS_RESET;
        end
        else
        begin
            settings <= setup_d; // RULE10
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            chargeDetectCtrl_q <= 2'h0;
        end
        else if (doWrite && busS && awAddr_q == OFS_CTRL && wStrb_q[0])
        begin
            chargeDetectCtrl_q <= wData_q[POS_CHGDET +: 2];
        end
    end

    // Foldback steps the advertisement down one setting, leaving the limit alone.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            advertisedNow <= SETTINGS_RESET.advertisedSourceCurrent;
        end
        else if (settings.thermalFoldbackOn && warnS
                 && settings.advertisedSourceCurrent != ADV_0A5)
        begin
            advertisedNow <= settings.advertisedSourceCurrent - 2'h1; // RULE1
        end
        else
        begin
            advertisedNow <= settings.advertisedSourceCurrent;
        end
    end

    // Mode comes from pins and the control bits only, so role swaps need no access.
    assign cdpWanted = chgS || (busS && chargeDetectCtrl_q != 2'h0); // RULE7

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            switchMode <= MODE_OFF;
            switchA <= 1'b0;
            switchB <= 1'b0;
        end
        else if (!hvS)
        begin
            switchMode <= MODE_OFF; // RULE18
            switchA <= 1'b0;
            switchB <= 1'b0;
        end
        else if (!supS)
        begin
            switchMode <= MODE_INVALID; // RULE6
            switchA <= 1'b0;
            switchB <= 1'b0;
        end
        else if (cdpWanted)
        begin
            switchMode <= MODE_CDP;
            switchA <= !detS; // RULE18
            switchB <= detS;
        end
        else
        begin
            switchMode <= MODE_PASS; // RULE9 RULE8
            switchA <= 1'b1;
            switchB <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            serialPinsAsStraps <= 1'b0;
            remoteCompActive <= 1'b0;
        end
        else
        begin
            serialPinsAsStraps <= !busS; // RULE14
            remoteCompActive <= remS && hvS; // RULE5
        end
    end

    // Write address and data are taken in either order, then answered together.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            awHeld_q <= 1'b0;
            awready <= 1'b1;
            awAddr_q <= '0;
        end
        else if (awvalid && awready)
        begin
            awHeld_q <= 1'b1;
            awready <= 1'b0;
            awAddr_q <= awaddr;
        end
        else if (bvalid && bready)
        begin
            awHeld_q <= 1'b0;
            awready <= 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wHeld_q <= 1'b0;
            wready <= 1'b1;
            wData_q <= '0;
            wStrb_q <= '0;
        end
        else if (wvalid && wready)
        begin
            wHeld_q <= 1'b1;
            wready <= 1'b0;
            wData_q <= wdata;
            wStrb_q <= wstrb;
        end
        else if (bvalid && bready)
        begin
            wHeld_q <= 1'b0;
            wready <= 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end
        else if (doWrite)
        begin
            bvalid <= 1'b1;
            bresp <= writeHit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bready)
        begin
            bvalid <= 1'b0;
        end
    end

    always_comb
    begin
        readHit = 1'b1;
        unique case (araddr)
            OFS_SETUP0:
                readWord = {26'h0, settings.slaveAddrLsb, 2'h0, settings.syncDirIn,
                            settings.spreadOn};
            OFS_SETUP1:
                readWord = {23'h0, settings.gain, 1'b0, settings.oscFrequencySelect};
            OFS_SETUP2:
                readWord = {23'h0, settings.thermalFoldbackOn, 2'h0,
                            settings.advertisedSourceCurrent, 1'b0, settings.limitValue};
            OFS_CTRL:
                readWord = {30'h0, chargeDetectCtrl_q};
            OFS_STATUS:
                readWord = {22'h0, serialPinsAsStraps, warnS, 2'h0, advertisedNow, switchMode};
            default:
            begin
                readWord = '0;
                readHit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= readWord;
            rresp <= readHit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid && rready)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_switch_off_disabled: assert property (!hvS |=> !switchA && !switchB // RULE18
        && switchMode == MODE_OFF) else $error("switches not off with enable low");
    a_invalid_no_supply: assert property (hvS && !supS |=> switchMode == MODE_INVALID // RULE6
        && !switchA) else $error("missing logic supply not flagged invalid");
    a_pass_at_start: assert property (hvS && supS && !chgS && chargeDetectCtrl_q == 2'h0 // RULE9
        |=> switchA && !switchB) else $error("pass-through not selected");
    a_cdp_detect_b: assert property (hvS && supS && chgS && detS // RULE18
        |=> switchMode == MODE_CDP && switchB && !switchA) else $error("auto mode switch wrong");
    a_fold_limit_kept: assert property ($rose(warnS) && !hvRise && !doWrite // RULE1
        |=> $stable(settings.limitValue) [*2]) else $error("foldback touched limit");
    a_fold_adv_step: assert property (settings.thermalFoldbackOn && warnS // RULE1
        && settings.advertisedSourceCurrent == ADV_3A0 |=> advertisedNow == ADV_1A5)
        else $error("foldback advertisement wrong");
    a_spread_preload: assert property (hvRise |=> settings.spreadOn // RULE11
        == !$past(stepOne[3]) && settings.syncDirIn == !$past(stepOne[2]))
        else $error("spread or sync preload wrong");
    a_addr_preload: assert property (hvRise |=> settings.slaveAddrLsb == $past(stepOne[1:0])) // RULE12
        else $error("address bits preload wrong");
    a_gain_straps: assert property (hvRise && !busS |=> settings.gain // RULE4
        == {$past(stepThree[2]), $past(stepTwo)}) else $error("gain preload wrong");
    a_limit_strap: assert property (hvRise && !busS && stepThree[1:0] == 2'h3 // RULE16
        |=> settings.limitValue == LIM_3A04 && settings.advertisedSourceCurrent == ADV_3A0)
        else $error("limit preload wrong");
    a_freq_strap: assert property (hvRise && !busS && stepOne[1:0] == 2'h1 // RULE13
        |=> settings.oscFrequencySelect == FREQ_488K) else $error("frequency preload wrong");
    a_write_answer: assert property (awHeld_q && wHeld_q && !bvalid |=> bvalid)
        else $error("write not answered");

    c_preload_strap: cover property (hvRise && !busS);
    c_cdp_mode: cover property (switchMode == MODE_CDP ##1 switchMode == MODE_PASS);
    c_fold_active: cover property (warnS && settings.thermalFoldbackOn);
    c_bus_write: cover property (doWrite && awAddr_q == OFS_SETUP2);

endmodule // startup_config
`default_nettype wire

/* File: sim/strap_model.sv */
// Behavioural model of the three strap resistors as seen through the measurement.
`timescale 1ns/1ps
`default_nettype none
module strap_model (
    // Clock.
    input wire logic clk,
    // Requested steps, strap one in the top nibble, and open flags.
    input wire logic [11:0] stepReq,
    input wire logic [2:0] openReq,
    // Measured codes.
    output logic [3:0] strapOne,
    output logic [3:0] strapTwo,
    output logic [3:0] strapThree,
    output logic [2:0] strapOpen
);
    logic [3:0] junk_q = 4'hA;

    // An open strap leaves a meaningless raw code that changes every cycle.
    always_ff @(posedge clk)
    begin
        junk_q <= ~junk_q;
    end

    assign strapOpen = openReq;
    assign strapOne = openReq[2] ? junk_q : stepReq[11:8];
    assign strapTwo = openReq[1] ? junk_q : stepReq[7:4];
    assign strapThree = openReq[0] ? junk_q : stepReq[3:0];
endmodule // strap_model
`default_nettype wire

/* File: sim/startup_config_tb_top.sv */
// Self-checking bench for the strap loader and switch-mode selector.
`timescale 1ns/1ps
`default_nettype none
module startup_config_tb_top;
    import strap_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp, advertisedNow;
    logic [31:0] rdata, data;
    logic [3:0] strapOne, strapTwo, strapThree;
    logic [2:0] strapOpen;
    logic [11:0] stepReq = 12'h000;
    logic [2:0] openReq = 3'h0;
    logic busVariant = 1'b1, highVoltageEnable = 1'b0, logicSupplyOk = 1'b1;
    logic chargeModeSelect = 1'b0, portDetect = 1'b0, thermalWarn = 1'b0, remoteSenseOn = 1'b0;
    settings_t settings;
    switch_mode_t switchMode;
    logic switchA, switchB, serialPinsAsStraps, remoteCompActive;
    int fail_count = 0;
    int n_checks = 0;
    logic [2:0] fq [4] = '{FREQ_2200K, FREQ_488K, FREQ_350K, FREQ_310K};
    logic [2:0] lm [4] = '{LIM_0A55, LIM_1A62, LIM_2A60, LIM_3A04};
    logic [1:0] ad [4] = '{ADV_0A5, ADV_1A5, ADV_1A5, ADV_3A0};

    initial
    begin
        forever #5 clk = ~clk;
    end

    startup_config dut (.clk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .strapOne, .strapTwo, .strapThree, .strapOpen, .busVariant,
        .highVoltageEnable, .logicSupplyOk, .chargeModeSelect, .portDetect, .thermalWarn,
        .remoteSenseOn, .settings, .advertisedNow, .switchMode, .switchA, .switchB,
        .serialPinsAsStraps, .remoteCompActive);

    strap_model partner (.clk, .stepReq, .openReq, .strapOne, .strapTwo, .strapThree,
        .strapOpen);

    task automatic summarize();
        if (fail_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic go(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic hang();
        fail_count++;
        $display("MISMATCH handshake expected answer seen none");
        summarize();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        go(1);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (n > 50) hang();
        end
        while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        int n = 0;
        go(1);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
            if (n > 50) hang();
        end
        while (rvalid !== 1'b1);
        resp = rresp;
        data = rdata;
        rready <= 1'b0;
    endtask

    // Straps are held steady well before the enable rises again.
    task automatic power();
        highVoltageEnable <= 1'b0;
        go(6);
        highVoltageEnable <= 1'b1;
        go(6);
    endtask

    task automatic mode(input logic [3:0] pins, input switch_mode_t m, input logic [1:0] ab);
        {highVoltageEnable, logicSupplyOk, chargeModeSelect, portDetect} <= pins;
        go(5);
        chk("mode", m, switchMode);
        if (m != MODE_INVALID) chk("switchAB", ab, {switchA, switchB});
    endtask

    task automatic t_bus_load();
        for (int i = 0; i < 16; i++)
        begin
            stepReq <= {i[3:0], 8'h00};
            power();
            chk("spread", !i[3], settings.spreadOn);
            chk("syncIn", !i[2], settings.syncDirIn);
            chk("addr", i[1:0], settings.slaveAddrLsb);
            rd(OFS_SETUP0);
            chk("setup0", {i[1:0], 2'b00, !i[2], !i[3]}, data[5:0]);
        end
        chk("pinsBus", 1'b0, serialPinsAsStraps);
    endtask

    task automatic t_strap_load();
        busVariant <= 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            stepReq <= {3{i[3:0]}};
            power();
            chk("freq", fq[i[1:0]], settings.oscFrequencySelect);
            chk("spreadS", !i[3], settings.spreadOn);
            chk("gain", {i[2], i[3:0]}, settings.gain);
            chk("limit", lm[i[1:0]], settings.limitValue);
            chk("adv", ad[i[1:0]], settings.advertisedSourceCurrent);
            chk("fold", !i[3], settings.thermalFoldbackOn);
        end
        chk("pinsStrap", 1'b1, serialPinsAsStraps);
    endtask

    task automatic t_open();
        stepReq <= 12'h000;
        openReq <= 3'h7;
        power();
        chk("openGain", 5'h1F, settings.gain);
        chk("openFreq", FREQ_310K, settings.oscFrequencySelect);
        chk("openLimit", LIM_3A04, settings.limitValue);
        openReq <= 3'h0;
    endtask

    task automatic t_modes();
        mode(4'b0111, MODE_OFF, 2'b00);
        mode(4'b1000, MODE_INVALID, 2'b00);
        mode(4'b1010, MODE_INVALID, 2'b00);
        mode(4'b1100, MODE_PASS, 2'b10);
        mode(4'b1101, MODE_PASS, 2'b10);
        mode(4'b1110, MODE_CDP, 2'b10);
        mode(4'b1111, MODE_CDP, 2'b01);
        busVariant <= 1'b1;
        mode(4'b1100, MODE_PASS, 2'b10);
        wr(OFS_CTRL, 32'h1);
        mode(4'b1101, MODE_CDP, 2'b01);
        wr(OFS_CTRL, 32'h0);
    endtask

    task automatic t_fold();
        busVariant <= 1'b0;
        stepReq <= 12'h033;
        power();
        chk("advNow", ADV_3A0, advertisedNow);
        thermalWarn <= 1'b1;
        remoteSenseOn <= 1'b1;
        go(5);
        chk("advFold", ADV_1A5, advertisedNow);
        chk("limitFold", LIM_3A04, settings.limitValue);
        chk("modeFold", MODE_PASS, switchMode);
        chk("remote", 1'b1, remoteCompActive);
        chk("gainRemote", 5'h03, settings.gain);
        thermalWarn <= 1'b0;
        remoteSenseOn <= 1'b0;
    endtask

    task automatic t_regs();
        busVariant <= 1'b1;
        go(4);
        wr(OFS_SETUP2, 32'h0000_0125);
        chk("bresp", RESP_OKAY, resp);
        chk("limitW", 3'h5, settings.limitValue);
        rd(OFS_SETUP2);
        chk("setup2", 32'h0000_0125, data);
        wr(8'h40, 32'h0);
        chk("brespBad", RESP_SLVERR, resp);
        rd(8'h40);
        chk("rrespBad", RESP_SLVERR, resp);
        chk("rdataBad", 32'h0, data);
        power();
        chk("limitKept", 3'h5, settings.limitValue);
        busVariant <= 1'b0;
        go(4);
        wr(OFS_SETUP2, 32'h0);
        chk("limitStrap", 3'h5, settings.limitValue);
        rd(OFS_STATUS);
        chk("strapPart", 1'b1, data[POS_STRAPPART]);
    endtask

    initial
    begin
        go(10);
        chk("settingsRst", SETTINGS_RESET, settings);
        chk("modeRst", MODE_OFF, switchMode);
        chk("switchRst", 2'b00, {switchA, switchB});
        reset <= 1'b0;
        t_bus_load();
        t_strap_load();
        t_open();
        t_modes();
        t_fold();
        t_regs();
        summarize();
    end
endmodule // startup_config_tb_top
`default_nettype wire
